// *** system_controller_pkg.sv ***
// constants and types shared by the system clock and power controller
package system_controller_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_STATUS    = 8'h00;
  localparam logic [7:0] ADDR_IRQ_SET   = 8'h04;
  localparam logic [7:0] ADDR_IRQ_CLR   = 8'h08;
  localparam logic [7:0] ADDR_IRQ_FLAGS = 8'h0c;
  localparam logic [7:0] ADDR_BOD_CTRL  = 8'h10;
  localparam logic [7:0] ADDR_OSC_BASE  = 8'h20;

  // ----------------------------------------------------------------
  // oscillator indices
  // ----------------------------------------------------------------
  localparam int NUM_OSC      = 6;
  localparam int OSC_MAIN_XTL = 0;
  localparam int OSC_SLOW_XTL = 1;
  localparam int OSC_INT_SLOW = 2;
  localparam int OSC_ULP      = 3;
  localparam int OSC_FAST     = 4;
  localparam int OSC_LOOP     = 5;

  // ----------------------------------------------------------------
  // oscillator control fields
  // ----------------------------------------------------------------
  localparam int OSC_CTRL_W   = 12;
  localparam int OSC_ENABLE   = 1;
  localparam int OSC_RUN_STBY = 6;
  localparam int OSC_ON_REQ   = 7;
  localparam int OSC_SU_LSB   = 8;
  localparam int OSC_SU_W     = 4;
  localparam logic [11:0] OSC_CTRL_RST = 12'h080;

  // ----------------------------------------------------------------
  // brown-out control fields
  // ----------------------------------------------------------------
  localparam int BOD_CTRL_W     = 8;
  localparam int BOD_IO_EN      = 1;
  localparam int BOD_CORE_EN    = 2;
  localparam int BOD_IO_RST     = 3;
  localparam int BOD_IO_IRQ     = 4;
  localparam int BOD_IO_SAMPLED = 5;
  localparam int BOD_CORE_SAMP  = 6;
  localparam int BOD_CORE_RST   = 7;
  localparam logic [7:0] BOD_CTRL_RST = 8'h00;

  // ----------------------------------------------------------------
  // status and interrupt bits
  // ----------------------------------------------------------------
  localparam int IRQ_W        = 8;
  localparam int IRQ_IO_BOD   = 6;
  localparam int IRQ_CORE_BOD = 7;
  localparam int STAT_BUSY    = 8;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ          = 100;
  localparam int SU_UNIT_US       = 1;
  localparam int SU_UNIT_CYC      = SU_UNIT_US * CLK_MHZ;
  localparam int CNT_W            = 12;
  localparam int SYNC_CYC         = 3;
  localparam int SYNC_W           = 2;

  typedef enum logic [1:0] {
    SLEEP_ACTIVE,
    SLEEP_IDLE,
    SLEEP_STANDBY
  } sleep_mode_t;

  typedef enum logic {
    APB_IDLE,
    APB_RESP
  } apb_state_t;

endpackage

// *** system_controller.sv ***
// system clock and power controller with apb register interface
//
// The APB register port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module system_controller (
  // clock and reset
  input  wire logic                         clk_i,
  input  wire logic                         reset_i,
  // apb slave
  input  wire logic                         psel_i,
  input  wire logic                         penable_i,
  input  wire logic                         pwrite_i,
  input  wire logic [7:0]                   paddr_i,
  input  wire logic [31:0]                  pwdata_i,
  output logic      [31:0]                  prdata_o,
  output logic                              pready_o,
  output logic                              pslverr_o,
  // access protection
  input  wire logic                         write_protect_i,
  input  wire logic                         debugger_access_i,
  // power manager and debug
  input  wire system_controller_pkg::sleep_mode_t     sleep_mode_i,
  input  wire logic                         debugger_cold_plug_i,
  // oscillator requests from peripherals
  input  wire logic [system_controller_pkg::NUM_OSC-1:0] periph_req_i,
  // brown-out detector comparators
  input  wire logic                         io_brownout_det_i,
  input  wire logic                         core_brownout_det_i,
  // oscillator and brown-out controls
  output logic [system_controller_pkg::NUM_OSC-1:0]   osc_run_o,
  output logic [system_controller_pkg::NUM_OSC-1:0]   clk_src_valid_o,
  output logic [1:0]                        xtal_pin_claim_o,
  output logic                              io_brownout_en_o,
  output logic                              core_brownout_en_o,
  output logic                              io_brownout_reset_o,
  output logic                              core_brownout_reset_o,
  // interrupt and wake
  output logic                              irq_o,
  output logic                              wake_o
);

  localparam int N = system_controller_pkg::NUM_OSC;
  localparam int IW = system_controller_pkg::IRQ_W;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    system_controller_pkg::apb_state_t                      apb;
    logic [31:0]                                  rdata;
    logic                                         ready;
    logic                                         err;
    logic [N-1:0][system_controller_pkg::OSC_CTRL_W-1:0]    osc_ctrl;
    logic [system_controller_pkg::OSC_CTRL_W-1:0]           loop_applied;
    logic [system_controller_pkg::BOD_CTRL_W-1:0]           bod_ctrl;
    logic [system_controller_pkg::BOD_CTRL_W-1:0]           bod_applied;
    logic                                         sync_busy;
    logic [system_controller_pkg::SYNC_W-1:0]               sync_cnt;
    logic [N-1:0][system_controller_pkg::CNT_W-1:0]         su_cnt;
    logic [N-1:0]                                 osc_ready;
    logic [N-1:0]                                 run;
    logic [IW-1:0]                                irq_en;
    logic [IW-1:0]                                irq_flags;
    logic                                         io_det_q;
    logic                                         core_det_q;
    logic [1:0]                                   claim;
    logic                                         io_en;
    logic                                         core_en;
    logic                                         io_rst;
    logic                                         core_rst;
    logic                                         irq;
    logic                                         wake;
  } state_t;

  state_t state_ff;
  state_t nxt_state;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // 0..3 fixed registers, 4 brown-out, 8..13 oscillators, 15 unmapped
  function automatic logic [3:0] reg_index(input logic [7:0] addr);
    logic [3:0] idx;
    idx = 4'hf;
    if (addr == system_controller_pkg::ADDR_STATUS) idx = 4'h0;
    else if (addr == system_controller_pkg::ADDR_IRQ_SET) idx = 4'h1;
    else if (addr == system_controller_pkg::ADDR_IRQ_CLR) idx = 4'h2;
    else if (addr == system_controller_pkg::ADDR_IRQ_FLAGS) idx = 4'h3;
    else if (addr == system_controller_pkg::ADDR_BOD_CTRL) idx = 4'h4;
    else if (addr >= system_controller_pkg::ADDR_OSC_BASE && addr[1:0] == 2'h0 &&
             addr < system_controller_pkg::ADDR_OSC_BASE + 8'(4 * N)) begin
      idx = 4'h8 + 4'(addr[4:2]);
    end
    return idx;
  endfunction

  function automatic logic [system_controller_pkg::CNT_W-1:0] su_limit(
    input logic [system_controller_pkg::OSC_CTRL_W-1:0] ctrl);
    logic [system_controller_pkg::CNT_W-1:0] code;
    code = system_controller_pkg::CNT_W'(
      ctrl[system_controller_pkg::OSC_SU_LSB +: system_controller_pkg::OSC_SU_W]);
    return system_controller_pkg::CNT_W'((code + 1) * system_controller_pkg::SU_UNIT_CYC);
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [3:0]                         idx;
    logic                               wr;
    logic                               prot;
    logic [N-1:0]                       run_n;
    logic [IW-1:0]                      set_ev;
    logic [IW-1:0]                      clr_ev;
    logic [system_controller_pkg::OSC_CTRL_W-1:0] c;
    logic                               want;
    logic                               standby;
    logic                               slow;
    logic [31:0]                        rd;
    logic                               io_active;
    logic                               core_active;
    idx = reg_index(paddr_i);
    wr = 1'b0;
    prot = 1'b0;
    run_n = '0;
    set_ev = '0;
    clr_ev = '0;
    c = '0;
    want = 1'b0;
    slow = 1'b0;
    rd = '0;
    io_active = 1'b0;
    core_active = 1'b0;
    standby = (sleep_mode_i == system_controller_pkg::SLEEP_STANDBY);
    nxt_state = state_ff;

    // apb: one wait state, write commits at the edge pready is seen
    case (state_ff.apb)
      system_controller_pkg::APB_IDLE: begin
        if (psel_i && penable_i) begin
          // flag register is exempt; debugger ignores protection
          prot = pwrite_i && write_protect_i && !debugger_access_i &&
                 idx != 4'h3;
          case (idx)
            4'h0: rd = {23'h0, state_ff.sync_busy,
                        state_ff.core_det_q, state_ff.io_det_q,
                        state_ff.osc_ready};
            4'h1: rd = {24'h0, state_ff.irq_en};
            4'h2: rd = {24'h0, state_ff.irq_en};
            4'h3: rd = {24'h0, state_ff.irq_flags};
            4'h4: rd = {24'h0, state_ff.bod_ctrl};
            default: begin
              if (idx[3]) begin
                rd = {20'h0, state_ff.osc_ctrl[idx[2:0]]};
              end
            end
          endcase
          nxt_state.rdata = pwrite_i ? 32'h0 : rd;
          nxt_state.err = (idx == 4'hf) || prot;
          nxt_state.ready = 1'b1;
          nxt_state.apb = system_controller_pkg::APB_RESP;
        end
      end
      system_controller_pkg::APB_RESP: begin
        wr = psel_i && penable_i && pwrite_i && !state_ff.err;
        nxt_state.ready = 1'b0;
        nxt_state.err = 1'b0;
        nxt_state.rdata = '0;
        nxt_state.apb = system_controller_pkg::APB_IDLE;
      end
      default: nxt_state.apb = system_controller_pkg::APB_IDLE;
    endcase

    if (wr) begin
      case (idx)
        4'h1: nxt_state.irq_en = state_ff.irq_en | pwdata_i[IW-1:0];
        4'h2: nxt_state.irq_en = state_ff.irq_en & ~pwdata_i[IW-1:0];
        4'h3: clr_ev = pwdata_i[IW-1:0];
        4'h4: begin
          nxt_state.bod_ctrl = pwdata_i[system_controller_pkg::BOD_CTRL_W-1:0];
          nxt_state.sync_busy = 1'b1;
          nxt_state.sync_cnt = '0;
        end
        default: begin
          if (idx[3]) begin
            nxt_state.osc_ctrl[idx[2:0]] =
              pwdata_i[system_controller_pkg::OSC_CTRL_W-1:0];
            if (idx[2:0] == 3'(system_controller_pkg::OSC_LOOP)) begin
              nxt_state.sync_busy = 1'b1;
              nxt_state.sync_cnt = '0;
            end
          end
        end
      endcase
    end

    // ----------------------------------------------------------------
    // write synchronisation into the slow domains
    // ----------------------------------------------------------------
    // both targets share one busy flag; a new write restarts the count
    if (state_ff.sync_busy && !wr) begin
      if (state_ff.sync_cnt == system_controller_pkg::SYNC_W'(
            system_controller_pkg::SYNC_CYC - 1)) begin
        nxt_state.sync_busy = 1'b0;
        nxt_state.bod_applied = state_ff.bod_ctrl;
        nxt_state.loop_applied =
          state_ff.osc_ctrl[system_controller_pkg::OSC_LOOP];
      end else begin
        nxt_state.sync_cnt = state_ff.sync_cnt + 1'b1;
      end
    end

    // ----------------------------------------------------------------
    // oscillator run decisions and start-up masking
    // ----------------------------------------------------------------
    // counters never pause, halted processor or not
    for (int i = 0; i < N; i++) begin
      c = (i == system_controller_pkg::OSC_LOOP) ? state_ff.loop_applied
                                       : state_ff.osc_ctrl[i];
      // the 32 kHz sources are not dropped by standby
      slow = (i == system_controller_pkg::OSC_SLOW_XTL) ||
             (i == system_controller_pkg::OSC_INT_SLOW);
      want = !c[system_controller_pkg::OSC_ON_REQ] || periph_req_i[i];
      if (i == system_controller_pkg::OSC_ULP) begin
        run_n[i] = 1'b1;
      end else if (!c[system_controller_pkg::OSC_ENABLE]) begin
        run_n[i] = 1'b0;
      end else if (sleep_mode_i == system_controller_pkg::SLEEP_ACTIVE) begin
        run_n[i] = 1'b1;
      end else if (!standby || slow) begin
        run_n[i] = want;
      end else begin
        // auto restart on wake follows from this being combinational
        run_n[i] = c[system_controller_pkg::OSC_RUN_STBY] && want;
      end
      nxt_state.run[i] = run_n[i];
      if (!state_ff.run[i]) begin
        nxt_state.su_cnt[i] = '0;
        nxt_state.osc_ready[i] = 1'b0;
      end else if (!state_ff.osc_ready[i]) begin
        if (state_ff.su_cnt[i] >= su_limit(c) - 1'b1) begin
          nxt_state.osc_ready[i] = 1'b1;
        end else begin
          nxt_state.su_cnt[i] = state_ff.su_cnt[i] + 1'b1;
        end
      end
      set_ev[i] = nxt_state.osc_ready[i] && !state_ff.osc_ready[i];
    end

    nxt_state.claim = {
      state_ff.osc_ctrl[system_controller_pkg::OSC_SLOW_XTL][system_controller_pkg::OSC_ENABLE],
      state_ff.osc_ctrl[system_controller_pkg::OSC_MAIN_XTL][system_controller_pkg::OSC_ENABLE]
    };

    // ----------------------------------------------------------------
    // brown-out detectors
    // ----------------------------------------------------------------
    io_active = state_ff.bod_applied[system_controller_pkg::BOD_IO_EN] &&
                (!standby ||
                 state_ff.bod_applied[system_controller_pkg::BOD_IO_SAMPLED]);
    core_active = state_ff.bod_applied[system_controller_pkg::BOD_CORE_EN] &&
                  (!standby ||
                   state_ff.bod_applied[system_controller_pkg::BOD_CORE_SAMP]);
    nxt_state.io_en = io_active;
    nxt_state.core_en = core_active;
    nxt_state.io_det_q = io_active && io_brownout_det_i;
    nxt_state.core_det_q = core_active && core_brownout_det_i;
    set_ev[system_controller_pkg::IRQ_IO_BOD] =
      io_active && io_brownout_det_i && !state_ff.io_det_q &&
      state_ff.bod_applied[system_controller_pkg::BOD_IO_IRQ];
    set_ev[system_controller_pkg::IRQ_CORE_BOD] =
      core_active && core_brownout_det_i && !state_ff.core_det_q;
    // cold-plugged debugger lets a too-high threshold be corrected
    nxt_state.io_rst = io_active && io_brownout_det_i &&
                       state_ff.bod_applied[system_controller_pkg::BOD_IO_RST] &&
                       !debugger_cold_plug_i;
    nxt_state.core_rst = core_active && core_brownout_det_i &&
                         state_ff.bod_applied[system_controller_pkg::BOD_CORE_RST];

    // ----------------------------------------------------------------
    // interrupts and wake
    // ----------------------------------------------------------------
    // set wins over a clear landing in the same cycle
    nxt_state.irq_flags = (state_ff.irq_flags & ~clr_ev) | set_ev;
    nxt_state.irq = |(nxt_state.irq_flags & nxt_state.irq_en);
    nxt_state.wake = standby && nxt_state.irq;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_ff <= '0;
      for (int i = 0; i < N; i++) begin
        state_ff.osc_ctrl[i] <= system_controller_pkg::OSC_CTRL_RST;
      end
      state_ff.loop_applied <= system_controller_pkg::OSC_CTRL_RST;
      state_ff.bod_ctrl <= system_controller_pkg::BOD_CTRL_RST;
      state_ff.bod_applied <= system_controller_pkg::BOD_CTRL_RST;
      state_ff.apb <= system_controller_pkg::APB_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata_o = state_ff.rdata;
  assign pready_o = state_ff.ready;
  assign pslverr_o = state_ff.err;
  assign osc_run_o = state_ff.run;
  // masked until start-up expires
  assign clk_src_valid_o = state_ff.osc_ready;
  assign xtal_pin_claim_o = state_ff.claim;
  assign io_brownout_en_o = state_ff.io_en;
  assign core_brownout_en_o = state_ff.core_en;
  assign io_brownout_reset_o = state_ff.io_rst;
  assign core_brownout_reset_o = state_ff.core_rst;
  assign irq_o = state_ff.irq;
  assign wake_o = state_ff.wake;

endmodule

`default_nettype wire

// *** system_controller_checker.sv ***
// port-level assertions for the system clock and power controller
`timescale 1ns/1ps
`default_nettype none

module system_controller_checker (
  // clock and reset
  input wire logic                            clk_i,
  input wire logic                            reset_i,
  // apb
  input wire logic                            psel_i,
  input wire logic                            penable_i,
  input wire logic [31:0]                     prdata_o,
  input wire logic                            pready_o,
  input wire logic                            pslverr_o,
  // power manager, debug, clock, brown-out reset and wake outputs
  input wire system_controller_pkg::sleep_mode_t        sleep_mode_i,
  input wire logic                            debugger_cold_plug_i,
  input wire logic [system_controller_pkg::NUM_OSC-1:0] osc_run_o,
  input wire logic [system_controller_pkg::NUM_OSC-1:0] clk_src_valid_o,
  input wire logic                            io_brownout_reset_o,
  input wire logic                            wake_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  chk_ulp_always_on: assert property (
    !$past(reset_i) |-> osc_run_o[3])
    else $error("ultra-low-power oscillator stopped");
  chk_ready_one_cycle: assert property (
    pready_o |=> !pready_o)
    else $error("pready held longer than one cycle");
  chk_answer_next: assert property (
    psel_i && penable_i && !pready_o |=> pready_o)
    else $error("access phase not answered in the next cycle");
  chk_rdata_quiet: assert property (
    !pready_o |-> prdata_o == 32'h0)
    else $error("read data driven outside the answer cycle");
  chk_err_with_ready: assert property (
    pslverr_o |-> pready_o)
    else $error("error flagged without ready");
  chk_src_after_run: assert property (
    $rose(clk_src_valid_o[0]) |-> $past(osc_run_o[0], 2))
    else $error("clock source unmasked before the oscillator ran");
  chk_cold_plug_mask: assert property (
    debugger_cold_plug_i && $past(debugger_cold_plug_i)
      |-> !io_brownout_reset_o)
    else $error("io brown-out reset not masked under cold plug");
  chk_wake_standby: assert property (
    wake_o |-> $past(sleep_mode_i) == system_controller_pkg::SLEEP_STANDBY)
    else $error("wake raised outside standby");

  cover property ($rose(wake_o));
  cover property (pslverr_o);
  cover property ($rose(clk_src_valid_o[0]));
endmodule

bind system_controller system_controller_checker
  system_controller_checker_inst (.clk_i, .reset_i, .psel_i, .penable_i,
  .prdata_o, .pready_o, .pslverr_o, .sleep_mode_i, .debugger_cold_plug_i,
  .osc_run_o, .clk_src_valid_o, .io_brownout_reset_o, .wake_o);

`default_nettype wire

// *** system_controller_test.sv ***
// self-checking testbench for the system clock and power controller
`timescale 1ns/1ps
`default_nettype none

module system_controller_test;
  localparam logic [31:0] EN = 32'h1 << system_controller_pkg::OSC_ENABLE;
  localparam logic [7:0]  OSC0 = system_controller_pkg::ADDR_OSC_BASE;
  localparam logic [7:0]  OSC1 = system_controller_pkg::ADDR_OSC_BASE + 8'h04;
  localparam logic [7:0]  FAST = system_controller_pkg::ADDR_OSC_BASE + 8'h10;
  logic                     clk_i = 1'b0;
  logic                     reset_i = 1'b1;
  logic                     psel_i = 1'b0;
  logic                     penable_i = 1'b0;
  logic                     pwrite_i = 1'b0;
  logic [7:0]               paddr_i = 8'h00;
  logic [31:0]              pwdata_i = 32'h0;
  logic                     write_protect_i = 1'b0;
  logic                     debugger_access_i = 1'b0;
  system_controller_pkg::sleep_mode_t sleep_mode_i = system_controller_pkg::SLEEP_ACTIVE;
  logic                     debugger_cold_plug_i = 1'b0;
  logic [5:0]               periph_req_i = 6'h00;
  logic                     io_brownout_det_i = 1'b0;
  logic                     core_brownout_det_i = 1'b0;
  logic [31:0]              prdata_o;
  logic                     pready_o;
  logic                     pslverr_o;
  logic [5:0]               osc_run_o;
  logic [5:0]               clk_src_valid_o;
  logic [1:0]               xtal_pin_claim_o;
  logic                     io_brownout_en_o;
  logic                     core_brownout_en_o;
  logic                     io_brownout_reset_o;
  logic                     core_brownout_reset_o;
  logic                     irq_o;
  logic                     wake_o;
  logic [31:0]              rdata;
  logic                     rerr;
  int                       n_fail = 0;
  int                       n_checks = 0;

  system_controller system_controller_inst (.clk_i, .reset_i, .psel_i,
    .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o,
    .pslverr_o, .write_protect_i, .debugger_access_i, .sleep_mode_i,
    .debugger_cold_plug_i, .periph_req_i, .io_brownout_det_i,
    .core_brownout_det_i, .osc_run_o, .clk_src_valid_o, .xtal_pin_claim_o,
    .io_brownout_en_o, .core_brownout_en_o, .io_brownout_reset_o,
    .core_brownout_reset_o, .irq_o, .wake_o);

  always #5 clk_i = ~clk_i;

  // ----------------------------------------------------------------
  // bus and compare tasks
  // ----------------------------------------------------------------
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // holds the whole request until pready is sampled; bounded wait
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge clk_i);
    psel_i    <= 1'b1;
    pwrite_i  <= wr;
    paddr_i   <= a;
    pwdata_i  <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (pready_o !== 1'b1 && k < 20);
    if (pready_o !== 1'b1) begin
      n_fail++;
      close_out();
    end
    rdata = prdata_o;
    rerr  = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    int   c;
    logic rs;
    logic oq;
    logic rq;
    logic e;
    tick(12);
    reset_i <= 1'b0;
    tick(3);
    check("run after reset", osc_run_o, 6'h08);
    apb(1'b0, OSC0, 32'h0);
    check("osc ctrl reset", rdata, system_controller_pkg::OSC_CTRL_RST);
    apb(1'b1, 8'h14, 32'h1);
    check("unmapped err", rerr, 1'b1);
    apb(1'b1, OSC0, EN);
    tick(2);
    check("crystal run", osc_run_o[0], 1'b1);
    check("crystal pins", xtal_pin_claim_o[0], 1'b1);
    tick(40);
    check("masked in startup", clk_src_valid_o[0], 1'b0);
    tick(80);
    check("source valid", clk_src_valid_o[0], 1'b1);
    apb(1'b0, system_controller_pkg::ADDR_STATUS, 32'h0);
    check("ready status", rdata[0], 1'b1);
    apb(1'b0, system_controller_pkg::ADDR_IRQ_FLAGS, 32'h0);
    check("ready flag", rdata[0], 1'b1);
    check("irq masked", irq_o, 1'b0);
    apb(1'b1, system_controller_pkg::ADDR_IRQ_SET, 32'h1);
    tick(3);
    check("irq raised", irq_o, 1'b1);
    apb(1'b1, system_controller_pkg::ADDR_IRQ_FLAGS, 32'h1);
    tick(3);
    check("irq after clear", irq_o, 1'b0);
    apb(1'b0, system_controller_pkg::ADDR_IRQ_FLAGS, 32'h0);
    check("no second edge", rdata[0], 1'b0);
    apb(1'b1, system_controller_pkg::ADDR_IRQ_CLR, 32'h1);
    apb(1'b0, system_controller_pkg::ADDR_IRQ_SET, 32'h0);
    check("enables cleared", rdata[0], 1'b0);
    for (c = 0; c < 24; c++) begin
      rs = c[2];
      oq = c[1];
      rq = c[0];
      sleep_mode_i <= system_controller_pkg::SLEEP_ACTIVE;
      apb(1'b1, FAST, EN | (32'(rs) << system_controller_pkg::OSC_RUN_STBY)
                         | (32'(oq) << system_controller_pkg::OSC_ON_REQ));
      sleep_mode_i <= system_controller_pkg::sleep_mode_t'(c / 8);
      periph_req_i <= {1'b0, rq, 4'h0};
      tick(3);
      e = (c < 8) || ((c < 16 || rs) && (!oq || rq));
      check("fast osc run", osc_run_o[4], e);
    end
    sleep_mode_i <= system_controller_pkg::SLEEP_ACTIVE;
    apb(1'b1, FAST, 32'h0);
    tick(2);
    check("fast osc off", osc_run_o[4], 1'b0);
    write_protect_i <= 1'b1;
    apb(1'b1, OSC1, EN);
    check("protected err", rerr, 1'b1);
    apb(1'b0, OSC1, 32'h0);
    check("write dropped", rdata, system_controller_pkg::OSC_CTRL_RST);
    apb(1'b1, system_controller_pkg::ADDR_IRQ_FLAGS, 32'h0);
    check("flags unprotected", rerr, 1'b0);
    debugger_access_i <= 1'b1;
    apb(1'b1, OSC1, EN);
    check("debugger write", rerr, 1'b0);
    write_protect_i   <= 1'b0;
    debugger_access_i <= 1'b0;
    tick(2);
    check("slow pins", xtal_pin_claim_o[1], 1'b1);
    apb(1'b1, system_controller_pkg::ADDR_BOD_CTRL, 32'h9e);
    check("not yet synced", io_brownout_en_o, 1'b0);
    tick(5);
    check("io det on", io_brownout_en_o, 1'b1);
    check("core det on", core_brownout_en_o, 1'b1);
    io_brownout_det_i <= 1'b1;
    tick(3);
    check("io reset", io_brownout_reset_o, 1'b1);
    apb(1'b0, system_controller_pkg::ADDR_STATUS, 32'h0);
    check("io det status", rdata[8:6], 3'b001);
    debugger_cold_plug_i <= 1'b1;
    tick(3);
    check("cold plug mask", io_brownout_reset_o, 1'b0);
    debugger_cold_plug_i <= 1'b0;
    core_brownout_det_i  <= 1'b1;
    tick(3);
    check("core reset", core_brownout_reset_o, 1'b1);
    io_brownout_det_i   <= 1'b0;
    core_brownout_det_i <= 1'b0;
    apb(1'b0, system_controller_pkg::ADDR_IRQ_FLAGS, 32'h0);
    check("bod flags", rdata[7:6], 2'b11);
    apb(1'b1, system_controller_pkg::ADDR_IRQ_FLAGS, 32'hff);
    apb(1'b1, system_controller_pkg::ADDR_IRQ_SET, 32'h40);
    sleep_mode_i <= system_controller_pkg::SLEEP_STANDBY;
    tick(3);
    check("continuous off", io_brownout_en_o, 1'b0);
    apb(1'b1, system_controller_pkg::ADDR_BOD_CTRL, 32'hbe);
    tick(5);
    check("sampled on", io_brownout_en_o, 1'b1);
    io_brownout_det_i <= 1'b1;
    tick(5);
    check("standby wake", wake_o, 1'b1);
    sleep_mode_i      <= system_controller_pkg::SLEEP_ACTIVE;
    io_brownout_det_i <= 1'b0;
    tick(3);
    check("wake ends", wake_o, 1'b0);
    close_out();
  end
endmodule

`default_nettype wire
